// File: hw/gpc_pkg.sv
// Package for the single GPIO pin configuration block.
// Assumes one 20 MHz clock and a plain register port.
package gpc_pkg;

  // Register map
  localparam logic [7:0] GPC_ADDR_CTRL  = 8'h00;
  localparam logic [7:0] GPC_ADDR_STAT  = 8'h01;
  localparam logic [7:0] GPC_CTRL_RESET = 8'h01;
  localparam logic [7:0] GPC_CTRL_WMASK = 8'h8F;

  // Field positions
  localparam int GPC_BIT_DIR    = 0;
  localparam int GPC_BIT_POL    = 1;
  localparam int GPC_BIT_FUNC_L = 2;
  localparam int GPC_BIT_ODRAIN = 7;

  // Status layout
  localparam int GPC_STAT_PIN  = 0;
  localparam int GPC_STAT_VAL  = 1;
  localparam int GPC_STAT_DRV  = 2;

  typedef enum logic [1:0]
  {
    GPC_FN_GPIO = 2'h0,
    GPC_FN_DSR  = 2'h1,
    GPC_FN_IRQ9 = 2'h2,
    GPC_FN_RSVD = 2'h3
  } gpc_func_e;

  typedef struct packed
  {
    logic      open_drain;
    gpc_func_e func;
    logic      invert;
    logic      is_input;
  } gpc_cfg_s;

  typedef struct packed
  {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gpc_bus_s;

  function automatic gpc_cfg_s gpc_decode(input logic [7:0] v);
    gpc_cfg_s c;
    c.open_drain = v[GPC_BIT_ODRAIN];
    c.func       = gpc_func_e'(v[GPC_BIT_FUNC_L +: 2]);
    c.invert     = v[GPC_BIT_POL];
    c.is_input   = v[GPC_BIT_DIR];
    return c;
  endfunction : gpc_decode

endpackage : gpc_pkg

// File: hw/gpc_regs.sv
// Pin configuration register with read port.
// Assumes one-cycle strobes, never both at once.
`timescale 1ns/1ps
module gpc_regs
  import gpc_pkg::*;
(
  // Clock and reset
  input  wire logic     sys_clk,
  input  wire logic     rst_b,
  // Register port
  input  wire gpc_bus_s bus,
  output logic [7:0]    rdata_r,
  // Status and config
  input  wire logic [7:0] stat,
  output logic [7:0]    ctrl_r
);

  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
      ctrl_r <= GPC_CTRL_RESET;
    else if (bus.wr && bus.addr == GPC_ADDR_CTRL)
      ctrl_r <= bus.wdata & GPC_CTRL_WMASK;

  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
      rdata_r <= 8'h00;
    else if (bus.rd)
    begin
      unique case (bus.addr)
        GPC_ADDR_CTRL: rdata_r <= ctrl_r;
        GPC_ADDR_STAT: rdata_r <= stat;
        default:       rdata_r <= 8'h00;
      endcase
    end
    else
      rdata_r <= 8'h00;

  a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ctrl_r[6:4] == 3'h0) else $error("reserved bits set");

  a_write_lands: assert property (@(posedge sys_clk) disable iff (!rst_b)
    bus.wr && bus.addr == GPC_ADDR_CTRL |=> ctrl_r == ($past(bus.wdata) & GPC_CTRL_WMASK))
    else $error("write not stored");

endmodule : gpc_regs

// File: hw/gpc_pad.sv
// Pad logic: direction, polarity and driver type.
// Assumes pin input already synchronous.
`timescale 1ns/1ps
module gpc_pad
  import gpc_pkg::*;
(
  // Config
  input  wire gpc_cfg_s cfg,
  // Core side
  input  wire logic     core_out,
  output logic          core_in,
  // Pin side
  input  wire logic     pin_in,
  output logic          pin_out,
  output logic          pin_oe
);

  logic drv;

  always_comb
  begin
    core_in = pin_in ^ cfg.invert;
    drv     = core_out ^ cfg.invert;
    pin_out = drv;
    // Open drain only pulls low
    if (cfg.is_input)
      pin_oe = 1'b0;
    else if (cfg.open_drain)
      pin_oe = ~drv;
    else
      pin_oe = 1'b1;
  end

endmodule : gpc_pad

// File: hw/gpc_top.sv
// Top of one GPIO pin with selectable alternate function.
// Assumes pin input synchronous to sys_clk; pin resolved outside.
`timescale 1ns/1ps
module gpc_top
  import gpc_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // Register port
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  output logic [7:0]      rdata,
  // Core functions
  input  wire logic       gpio_out,
  input  wire logic       irq9_in,
  output logic            gpio_in_r,
  output logic            second_serial_data_set_ready_r,
  // Pin
  input  wire logic       general_purpose_pin_5_4_in,
  output logic            general_purpose_pin_5_4_out_r,
  output logic            general_purpose_pin_5_4_oe_r
);

  gpc_bus_s   bus;
  gpc_cfg_s   cfg;
  logic [7:0] ctrl_r;
  logic [7:0] stat;
  logic       core_in;
  logic       core_out;
  logic       pad_out;
  logic       pad_oe;

  assign bus = '{wr: wr_stb, rd: rd_stb, addr: addr, wdata: wdata};
  assign cfg = gpc_decode(ctrl_r);

  gpc_regs u_regs
  (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .bus     (bus),
    .rdata_r (rdata),
    .stat    (stat),
    .ctrl_r  (ctrl_r)
  );

  // Output source by function; reserved drives idle
  always_comb
  begin
    unique case (cfg.func)
      GPC_FN_GPIO: core_out = gpio_out;
      GPC_FN_IRQ9: core_out = irq9_in;
      GPC_FN_DSR:  core_out = 1'b0;
      GPC_FN_RSVD: core_out = 1'b0;
    endcase
  end

  gpc_pad u_pad
  (
    .cfg      (cfg),
    .core_out (core_out),
    .core_in  (core_in),
    .pin_in   (general_purpose_pin_5_4_in),
    .pin_out  (pad_out),
    .pin_oe   (pad_oe)
  );

  // Registered pin drive; one cycle of latency keeps outputs glitch free
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      general_purpose_pin_5_4_out_r <= 1'b0;
      general_purpose_pin_5_4_oe_r  <= 1'b0;
    end
    else
    begin
      general_purpose_pin_5_4_out_r <= pad_out;
      general_purpose_pin_5_4_oe_r  <= pad_oe;
    end

  // Input delivery by function; idle level is high for the active-low DSR
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      gpio_in_r                      <= 1'b0;
      second_serial_data_set_ready_r <= 1'b1;
    end
    else
    begin
      gpio_in_r                      <= (cfg.func == GPC_FN_GPIO) ? core_in : 1'b0;
      second_serial_data_set_ready_r <= (cfg.func == GPC_FN_DSR) ? core_in : 1'b1;
    end

  assign stat = {5'h00, general_purpose_pin_5_4_oe_r, core_out, general_purpose_pin_5_4_in};

  // Short names for the checks below
  logic       pin_now;
  logic       oe_now;
  logic       out_now;
  logic [7:0] shadow_r;

  assign pin_now = general_purpose_pin_5_4_in;
  assign oe_now  = general_purpose_pin_5_4_oe_r;
  assign out_now = general_purpose_pin_5_4_out_r;

  // Field-by-field copy of the register, built apart from the write mask on purpose
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
      shadow_r <= GPC_CTRL_RESET;
    else if (wr_stb && addr == GPC_ADDR_CTRL)
      shadow_r <= {wdata[GPC_BIT_ODRAIN], 3'h0, wdata[GPC_BIT_FUNC_L +: 2],
                   wdata[GPC_BIT_POL], wdata[GPC_BIT_DIR]};

  // Direction and status read
  a_input_no_drive: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cfg.is_input |=> !oe_now)
    else $error("input pin driven");

  a_oe_needs_output: assert property (@(posedge sys_clk) disable iff (!rst_b)
    oe_now |-> !$past(cfg.is_input))
    else $error("driven while input");

  a_input_odrain_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cfg.is_input && cfg.open_drain |=> !oe_now)
    else $error("open drain input driven");

  a_input_dsr_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cfg.is_input && cfg.func == GPC_FN_DSR |=> !oe_now)
    else $error("dsr input driven");

  a_input_irq_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cfg.is_input && cfg.func == GPC_FN_IRQ9 |=> !oe_now)
    else $error("irq input driven");

  a_status_reads: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rd_stb && addr == GPC_ADDR_STAT |=> rdata == $past(stat))
    else $error("status read wrong");

  // Polarity and drive value
  a_out_polarity: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cfg.func == GPC_FN_GPIO |=> out_now == ($past(gpio_out) ^ $past(cfg.invert)))
    else $error("output polarity wrong");

  a_in_polarity: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cfg.func == GPC_FN_GPIO |=> gpio_in_r == ($past(pin_now) ^ $past(cfg.invert)))
    else $error("input polarity wrong");

  a_out_plain: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cfg.func == GPC_FN_GPIO && !cfg.invert |=> out_now == $past(gpio_out))
    else $error("plain output changed");

  a_out_inverted: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cfg.func == GPC_FN_GPIO && cfg.invert |=> out_now != $past(gpio_out))
    else $error("output not inverted");

  a_in_plain: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cfg.func == GPC_FN_GPIO && !cfg.invert |=> gpio_in_r == $past(pin_now))
    else $error("plain input changed");

  a_in_inverted: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cfg.func == GPC_FN_GPIO && cfg.invert |=> gpio_in_r != $past(pin_now))
    else $error("input not inverted");

  a_dsr_polarity: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cfg.func == GPC_FN_DSR |=> second_serial_data_set_ready_r == ($past(pin_now) ^ $past(cfg.invert)))
    else $error("dsr polarity wrong");

  a_irq_inverted: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cfg.func == GPC_FN_IRQ9 && cfg.invert |=> out_now != $past(irq9_in))
    else $error("irq9 not inverted");

  a_drive_value: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !cfg.is_input |=> out_now == $past(pad_out))
    else $error("drive value lost");

  // Function select
  a_dsr_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cfg.func != GPC_FN_DSR |=> second_serial_data_set_ready_r)
    else $error("dsr not idle");

  a_irq_route: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cfg.func == GPC_FN_IRQ9 && !cfg.invert |=> out_now == $past(irq9_in))
    else $error("irq9 not routed");

  a_in_gpio_only: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cfg.func != GPC_FN_GPIO |=> !gpio_in_r)
    else $error("gpio input outside gpio");

  a_dsr_plain: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cfg.func == GPC_FN_DSR && !cfg.invert |=> second_serial_data_set_ready_r == $past(pin_now))
    else $error("dsr not routed");

  a_dsr_inverted: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cfg.func == GPC_FN_DSR && cfg.invert |=> second_serial_data_set_ready_r != $past(pin_now))
    else $error("dsr not inverted");

  a_dsr_drive_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cfg.func == GPC_FN_DSR |=> out_now == $past(cfg.invert))
    else $error("dsr drive not idle");

  a_rsvd_drive_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cfg.func == GPC_FN_RSVD |=> out_now == $past(cfg.invert))
    else $error("reserved drive not idle");

  a_rsvd_no_input: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cfg.func == GPC_FN_RSVD |=> !gpio_in_r && second_serial_data_set_ready_r)
    else $error("reserved delivered input");

  a_irq_no_input: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cfg.func == GPC_FN_IRQ9 |=> !gpio_in_r && second_serial_data_set_ready_r)
    else $error("irq9 delivered input");

  a_core_gpio: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cfg.func == GPC_FN_GPIO |-> core_out == gpio_out)
    else $error("gpio source not selected");

  a_core_irq: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cfg.func == GPC_FN_IRQ9 |-> core_out == irq9_in)
    else $error("irq9 source not selected");

  a_core_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cfg.func == GPC_FN_DSR || cfg.func == GPC_FN_RSVD |-> !core_out)
    else $error("idle source not low");

  // Driver type
  a_pushpull_drives: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !cfg.is_input && !cfg.open_drain |=> oe_now)
    else $error("push-pull not driving");

  a_odrain_high_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !cfg.is_input && cfg.open_drain && pad_out |=> !oe_now)
    else $error("open drain drove high");

  a_odrain_low_on: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !cfg.is_input && cfg.open_drain && !pad_out |=> oe_now && !out_now)
    else $error("open drain not pulling low");

  a_odrain_never_high: assert property (@(posedge sys_clk) disable iff (!rst_b)
    oe_now && $past(cfg.open_drain) |-> !out_now)
    else $error("open drain driving high");

  a_pushpull_high: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !cfg.is_input && !cfg.open_drain && pad_out |=> oe_now && out_now)
    else $error("push-pull high missing");

  a_pushpull_low: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !cfg.is_input && !cfg.open_drain && !pad_out |=> oe_now && !out_now)
    else $error("push-pull low missing");

  // Register port and reset
  a_reset_value: assert property (@(posedge sys_clk)
    $rose(rst_b) |-> ctrl_r == GPC_CTRL_RESET)
    else $error("bad reset value");

  a_reset_outputs: assert property (@(posedge sys_clk)
    $rose(rst_b) |-> !oe_now && !out_now && !gpio_in_r && second_serial_data_set_ready_r && rdata == 8'h00)
    else $error("bad output after reset");

  a_shadow_match: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ctrl_r == shadow_r)
    else $error("register copy differs");

  a_ctrl_read: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rd_stb && addr == GPC_ADDR_CTRL |=> rdata == $past(shadow_r))
    else $error("register read wrong");

  a_ctrl_holds: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !wr_stb |=> $stable(ctrl_r))
    else $error("register changed unwritten");

  a_write_other: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wr_stb && addr != GPC_ADDR_CTRL |=> $stable(ctrl_r))
    else $error("stray write landed");

  a_read_rsvd_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rd_stb && addr == GPC_ADDR_CTRL |=> rdata[6:4] == 3'h0)
    else $error("reserved bits read set");

  a_read_unmapped: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rd_stb && addr != GPC_ADDR_CTRL && addr != GPC_ADDR_STAT |=> rdata == 8'h00)
    else $error("unmapped read not zero");

  a_read_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !rd_stb |=> rdata == 8'h00)
    else $error("read data outside read");

  a_write_dir: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wr_stb && addr == GPC_ADDR_CTRL |=> ctrl_r[GPC_BIT_DIR] == $past(wdata[GPC_BIT_DIR]))
    else $error("direction bit not stored");

  a_write_pol: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wr_stb && addr == GPC_ADDR_CTRL |=> ctrl_r[GPC_BIT_POL] == $past(wdata[GPC_BIT_POL]))
    else $error("polarity bit not stored");

  a_write_odrain: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wr_stb && addr == GPC_ADDR_CTRL |=> ctrl_r[GPC_BIT_ODRAIN] == $past(wdata[GPC_BIT_ODRAIN]))
    else $error("driver bit not stored");

endmodule : gpc_top

// File: bench/gpc_pin_model.sv
// Board around the pin: a pull-up and one external driver.
// Assumes oe is high while the design drives the pin.
`timescale 1ns/1ps
module gpc_pin_model
(
  // Design side
  input  wire logic oe,
  input  wire logic out,
  // Board side
  input  wire logic ext_en,
  input  wire logic ext_val,
  output logic      level
);
  // Pull-up only when nobody drives, so a released open drain reads high
  assign level = oe ? out : (ext_en ? ext_val : 1'b1);
endmodule : gpc_pin_model

// File: bench/testbench.sv
// Testbench for the pin configuration block.
// Assumes reads answered the cycle after the strobe.
`timescale 1ns/1ps
module testbench;
  import gpc_pkg::*;
  logic       sys_clk, rst_b, wr_stb, rd_stb, gpio_out, irq9_in, ext_en, ext_val, pin;
  logic       gin, dsr, pout, poe;
  logic [7:0] addr, wdata, rdata;
  int         fail_count, tests_run;
  // Per case: cfg, {gpio_out, irq9, ext_en, ext_val}, {gin, dsr, out, oe}, mask
  localparam logic [19:0] TV [10] = '{20'h013CF, 20'h0336F, 20'h00877, 20'h02857, 20'h0847F,
                                     20'h0520F, 20'h0732F, 20'h808CD, 20'h80057, 20'h0D34D};

  gpc_top u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .gpio_out(gpio_out), .irq9_in(irq9_in), .gpio_in_r(gin),
    .second_serial_data_set_ready_r(dsr), .general_purpose_pin_5_4_in(pin),
    .general_purpose_pin_5_4_out_r(pout), .general_purpose_pin_5_4_oe_r(poe));
  gpc_pin_model u_pin (.oe(poe), .out(pout), .ext_en(ext_en), .ext_val(ext_val), .level(pin));

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rd

  task results;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Whole run is about a hundred cycles
  initial
  begin
    #200000;
    fail_count++;
    results();
  end

  initial
  begin
    {rst_b, wr_stb, rd_stb, gpio_out, irq9_in, ext_val} = '0;
    ext_en = 1'b1;
    addr   = 8'h00;
    wdata  = 8'h00;
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(GPC_ADDR_CTRL, GPC_CTRL_RESET);
    chk({4'h0, gin, dsr, pout, poe}, 8'h04);
    wr(GPC_ADDR_CTRL, 8'hFF);
    rd(GPC_ADDR_CTRL, 8'h8F);
    wr(8'h7E, 8'h00);
    rd(GPC_ADDR_CTRL, 8'h8F);
    rd(8'h7E, 8'h00);
    for (int i = 0; i < 10; i++)
    begin
      @(posedge sys_clk);
      {gpio_out, irq9_in, ext_en, ext_val} <= TV[i][11:8];
      wr(GPC_ADDR_CTRL, TV[i][19:12]);
      // Extra cycles let the pin level come back through the input flop
      repeat (4) @(posedge sys_clk);
      #1;
      chk({4'h0, gin, dsr, pout, poe} & {4'h0, TV[i][3:0]}, {4'h0, TV[i][7:4]});
    end
    rd(GPC_ADDR_STAT, 8'h01);
    rd(GPC_ADDR_CTRL, 8'h0D);
    results();
  end
endmodule : testbench
